// ===== dmq_pkg.sv
package dmq_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] DMQ_CTRL_OFS = 8'h00;
  localparam logic [7:0] DMQ_ADDR_OFS = 8'h04;
  localparam logic [7:0] DMQ_CNT_OFS = 8'h08;
  localparam logic [7:0] DMQ_TADDR_OFS = 8'h0C;
  localparam logic [7:0] DMQ_TCNT_OFS = 8'h10;
  localparam logic [7:0] DMQ_XCFG_OFS = 8'h14;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int DMQ_EN_BIT = 0;
  localparam int DMQ_QPEND_BIT = 1;
  localparam int DMQ_CTE_BIT = 2;
  localparam int DMQ_TTE_BIT = 3;
  localparam int DMQ_CTI_BIT = 4;
  localparam int DMQ_TTI_BIT = 5;
  localparam int DMQ_PERIPHERAL_ADDR_FIELD_LSB = 24;
  localparam int DMQ_FIELD_W = 24;
  localparam logic [31:0] DMQ_CTRL_RST = 32'h0000_0000;
  // ****************************************
  // External access
  // ****************************************
  localparam logic [31:0] DMQ_ROM_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] DMQ_ROM_LIMIT_RST = 32'h3FFF_FFFF;
  localparam logic [31:0] DMQ_DRAM_BASE_RST = 32'h4000_0000;
  localparam logic [31:0] DMQ_DRAM_LIMIT_RST = 32'h4FFF_FFFF;
  localparam logic [3:0] DMQ_MEM_WAIT_RST = 4'h3;
  typedef enum logic [2:0] {
    DMQ_X_IDLE,
    DMQ_X_GRANT,
    DMQ_X_SETUP,
    DMQ_X_WAIT,
    DMQ_X_DONE
  } dmq_xstate_t;
endpackage

// ===== dmq_sync.sv
`timescale 1ns/100ps
`default_nettype none
module dmq_sync
  #(parameter logic RST_VAL = 1'b1)
  (
  // Clock
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Data
  input wire logic d_i,
  output logic q_o
  );
  logic meta_q;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL;
      q_o <= RST_VAL;
    end
    else if (ce_i)
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== dmq_xacc.sv
`timescale 1ns/100ps
`default_nettype none
module dmq_xacc
  import dmq_pkg::*;
  (
  // Clock
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Handshake
  input wire logic req_n_s_i,
  input wire logic cpu_busy_i,
  input wire logic [31:0] bus_i,
  output logic grant_n_o,
  output logic bus_hold_o,
  // Memory side
  input wire logic [31:0] rom_base_i,
  input wire logic [31:0] rom_limit_i,
  input wire logic [31:0] dram_base_i,
  input wire logic [31:0] dram_limit_i,
  input wire logic [3:0] wait_i,
  output logic [31:0] addr_o,
  output logic rom_cs_n_o,
  output logic dram_cs_n_o,
  output logic rom_output_enable_n_o,
  output logic mem_we_n_o,
  output logic addr_err_o
  );
  dmq_xstate_t st_q;
  logic [3:0] cnt_q;
  logic is_rom_q;
  wire is_rom = (bus_i >= rom_base_i) && (bus_i <= rom_limit_i);
  wire is_dram = (bus_i >= dram_base_i) && (bus_i <= dram_limit_i);
  // Zero-wait accesses unsupported: at least one wait
  wire [3:0] wait_n = (wait_i == 4'h0) ? 4'h1 : wait_i;
  assign bus_hold_o = (st_q != DMQ_X_IDLE);
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= DMQ_X_IDLE;
      cnt_q <= 4'h0;
      is_rom_q <= 1'b0;
      grant_n_o <= 1'b1;
      addr_o <= 32'h0000_0000;
      rom_cs_n_o <= 1'b1;
      dram_cs_n_o <= 1'b1;
      rom_output_enable_n_o <= 1'b1;
      mem_we_n_o <= 1'b1;
      addr_err_o <= 1'b0;
    end
    else if (ce_i)
    begin
      addr_err_o <= 1'b0;
      case (st_q)
        DMQ_X_IDLE:
        begin
          // Grant only between own accesses
          if (!req_n_s_i && !cpu_busy_i)
          begin
            grant_n_o <= 1'b0;
            st_q <= DMQ_X_GRANT;
          end
        end
        DMQ_X_GRANT:
        begin
          if (req_n_s_i)
          begin
            // Address taken from shared bus
            addr_o <= {bus_i[31:2], 2'b00};
            cnt_q <= wait_n;
            is_rom_q <= is_rom;
            if (is_rom || is_dram)
            begin
              rom_cs_n_o <= !is_rom;
              dram_cs_n_o <= is_rom;
              rom_output_enable_n_o <= !is_rom;
              st_q <= DMQ_X_SETUP;
            end
            else
            begin
              addr_err_o <= 1'b1;
              grant_n_o <= 1'b1;
              st_q <= DMQ_X_DONE;
            end
          end
        end
        DMQ_X_SETUP:
        begin
          // Write strobe asserted for DRAM accesses only, regardless of direction
          mem_we_n_o <= is_rom_q;
          st_q <= DMQ_X_WAIT;
        end
        DMQ_X_WAIT:
        begin
          cnt_q <= cnt_q - 4'h1;
          if (cnt_q == 4'h1)
          begin
            grant_n_o <= 1'b1;
            mem_we_n_o <= 1'b1;
            st_q <= DMQ_X_DONE;
          end
        end
        default:
        begin
          rom_cs_n_o <= 1'b1;
          dram_cs_n_o <= 1'b1;
          rom_output_enable_n_o <= 1'b1;
          st_q <= DMQ_X_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== dmq_top.sv
`timescale 1ns/100ps
`default_nettype none
module dmq_top
  import dmq_pkg::*;
  (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // DMA channel zero
  input wire logic xfer_done_i,
  input wire logic external_terminate_in,
  output logic [31:0] ch_addr_o,
  output logic ch_active_o,
  output logic count_end_irq_o,
  output logic terminate_irq_o,
  // External access
  input wire logic ext_access_request_n,
  input wire logic cpu_busy_i,
  input wire logic [31:0] shared_data_bus_i,
  output logic ext_access_grant_n,
  output logic bus_hold_o,
  output logic hiz_force_o,
  output logic [31:0] mem_addr_o,
  output logic rom_cs_n_o,
  output logic dram_cs_n_o,
  output logic rom_output_enable_n,
  output logic mem_we_n_o,
  output logic addr_err_o
  );
  // ****************************************
  // Registers
  // ****************************************
  logic enable_q;
  logic queue_pending_bit;
  logic count_end_irq_enable;
  logic terminate_irq_enable;
  logic count_end_irq_flag;
  logic terminate_irq_flag;
  logic [7:0] peripheral_addr_field;
  logic [DMQ_FIELD_W-1:0] head_addr_q;
  logic [DMQ_FIELD_W-1:0] head_cnt_q;
  logic [DMQ_FIELD_W-1:0] tail_addr_q;
  logic [DMQ_FIELD_W-1:0] tail_cnt_q;
  logic [31:0] rom_base_q;
  logic [31:0] rom_limit_q;
  logic [31:0] dram_base_q;
  logic [31:0] dram_limit_q;
  logic [3:0] mem_wait_q;
  logic term_s;
  logic req_n_s;
  // ****************************************
  // APB decode
  // ****************************************
  wire wr_en = psel_i && penable_i && pwrite_i;
  wire wr_ctrl = wr_en && (paddr_i == DMQ_CTRL_OFS);
  wire wr_addr = wr_en && (paddr_i == DMQ_ADDR_OFS);
  wire wr_cnt = wr_en && (paddr_i == DMQ_CNT_OFS);
  wire wr_taddr = wr_en && (paddr_i == DMQ_TADDR_OFS);
  wire wr_tcnt = wr_en && (paddr_i == DMQ_TCNT_OFS);
  wire wr_xcfg = wr_en && (paddr_i == DMQ_XCFG_OFS);
  wire [31:0] ctrl_rd = {peripheral_addr_field, 18'h0_0000,
    terminate_irq_flag, count_end_irq_flag, terminate_irq_enable,
    count_end_irq_enable, queue_pending_bit, enable_q};
  wire known = (paddr_i == DMQ_CTRL_OFS) || (paddr_i == DMQ_ADDR_OFS) ||
    (paddr_i == DMQ_CNT_OFS) || (paddr_i == DMQ_TADDR_OFS) ||
    (paddr_i == DMQ_TCNT_OFS) || (paddr_i == DMQ_XCFG_OFS);
  logic [31:0] rd_mux;
  always_comb
  begin
    if (paddr_i == DMQ_CTRL_OFS)
      rd_mux = ctrl_rd;
    else if (paddr_i == DMQ_ADDR_OFS)
      rd_mux = {peripheral_addr_field, head_addr_q};
    else if (paddr_i == DMQ_CNT_OFS)
      rd_mux = {8'h00, head_cnt_q};
    else if (paddr_i == DMQ_XCFG_OFS)
      rd_mux = {28'h000_0000, mem_wait_q};
    else
      rd_mux = 32'h0000_0000; // Tails are write-only
  end
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !known;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      prdata_o <= 32'h0000_0000;
    else if (ce_i && psel_i && !penable_i)
      prdata_o <= rd_mux;
  end
  // ****************************************
  // Channel termination
  // ****************************************
  dmq_sync #(.RST_VAL(1'b0)) u_term_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(external_terminate_in),
    .q_o(term_s)
  );
  wire cnt_end = enable_q && xfer_done_i && (head_cnt_q == '0);
  wire term_hit = enable_q && xfer_done_i && term_s && terminate_irq_enable;
  wire cnt_hit = cnt_end && count_end_irq_enable;
  wire stop = term_hit || cnt_end;
  wire advance = stop && queue_pending_bit;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      enable_q <= DMQ_CTRL_RST[DMQ_EN_BIT];
      queue_pending_bit <= DMQ_CTRL_RST[DMQ_QPEND_BIT];
      count_end_irq_enable <= DMQ_CTRL_RST[DMQ_CTE_BIT];
      terminate_irq_enable <= DMQ_CTRL_RST[DMQ_TTE_BIT];
      count_end_irq_flag <= DMQ_CTRL_RST[DMQ_CTI_BIT];
      terminate_irq_flag <= DMQ_CTRL_RST[DMQ_TTI_BIT];
      peripheral_addr_field <= 8'h00;
      head_addr_q <= '0;
      head_cnt_q <= '0;
      tail_addr_q <= '0;
      tail_cnt_q <= '0;
    end
    else if (ce_i)
    begin
      if (wr_ctrl)
      begin
        enable_q <= pwdata_i[DMQ_EN_BIT];
        queue_pending_bit <= pwdata_i[DMQ_QPEND_BIT];
        count_end_irq_enable <= pwdata_i[DMQ_CTE_BIT];
        terminate_irq_enable <= pwdata_i[DMQ_TTE_BIT];
        count_end_irq_flag <= pwdata_i[DMQ_CTI_BIT];
        terminate_irq_flag <= pwdata_i[DMQ_TTI_BIT];
      end
      if (wr_addr)
      begin
        peripheral_addr_field <= pwdata_i[31:DMQ_PERIPHERAL_ADDR_FIELD_LSB];
        head_addr_q <= pwdata_i[DMQ_FIELD_W-1:0];
      end
      if (wr_cnt)
        head_cnt_q <= pwdata_i[DMQ_FIELD_W-1:0];
      else if (enable_q && xfer_done_i && !stop)
        head_cnt_q <= head_cnt_q - {{(DMQ_FIELD_W-1){1'b0}}, 1'b1};
      if (wr_tcnt)
        tail_cnt_q <= pwdata_i[DMQ_FIELD_W-1:0];
      if (wr_taddr)
      begin
        tail_addr_q <= pwdata_i[DMQ_FIELD_W-1:0];
        queue_pending_bit <= 1'b1;
        count_end_irq_flag <= 1'b0;
        terminate_irq_flag <= 1'b0;
      end
      if (stop)
      begin
        if (advance)
        begin
          head_addr_q <= tail_addr_q;
          head_cnt_q <= tail_cnt_q;
          queue_pending_bit <= 1'b0;
        end
        else
          enable_q <= 1'b0;
        if (cnt_hit)
          count_end_irq_flag <= 1'b1;
        if (term_hit)
          terminate_irq_flag <= 1'b1;
      end
    end
  end
  assign ch_addr_o = {peripheral_addr_field, head_addr_q};
  assign ch_active_o = enable_q;
  assign count_end_irq_o = count_end_irq_flag;
  assign terminate_irq_o = terminate_irq_flag;
  // ****************************************
  // External memory access
  // ****************************************
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rom_base_q <= DMQ_ROM_BASE_RST;
      rom_limit_q <= DMQ_ROM_LIMIT_RST;
      dram_base_q <= DMQ_DRAM_BASE_RST;
      dram_limit_q <= DMQ_DRAM_LIMIT_RST;
      mem_wait_q <= DMQ_MEM_WAIT_RST;
    end
    else if (ce_i && wr_xcfg)
      mem_wait_q <= pwdata_i[3:0];
  end
  dmq_sync #(.RST_VAL(1'b1)) u_req_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .d_i(ext_access_request_n),
    .q_o(req_n_s)
  );
  // Request low during reset floats outputs
  assign hiz_force_o = !rst_n_i && !ext_access_request_n;
  dmq_xacc u_xacc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .req_n_s_i(req_n_s),
    .cpu_busy_i(cpu_busy_i),
    .bus_i(shared_data_bus_i),
    .grant_n_o(ext_access_grant_n),
    .bus_hold_o(bus_hold_o),
    .rom_base_i(rom_base_q),
    .rom_limit_i(rom_limit_q),
    .dram_base_i(dram_base_q),
    .dram_limit_i(dram_limit_q),
    .wait_i(mem_wait_q),
    .addr_o(mem_addr_o),
    .rom_cs_n_o(rom_cs_n_o),
    .dram_cs_n_o(dram_cs_n_o),
    .rom_output_enable_n_o(rom_output_enable_n),
    .mem_we_n_o(mem_we_n_o),
    .addr_err_o(addr_err_o)
  );
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i || !ce_i);
  tail_sets_pend_a: assert property (wr_taddr && !stop |=> queue_pending_bit)
    else $error("tail write did not set pending");
  tail_clr_flag_a: assert property (wr_taddr && !stop |=> !count_end_irq_flag && !terminate_irq_flag)
    else $error("tail write did not clear flags");
  adv_keeps_en_a: assert property (advance && !wr_ctrl && !wr_taddr |=> enable_q && !queue_pending_bit)
    else $error("advance lost enable");
  adv_loads_head_a: assert property (advance && !wr_cnt |=> head_cnt_q == $past(tail_cnt_q))
    else $error("advance did not load head");
  under_clr_en_a: assert property (stop && !queue_pending_bit && !wr_taddr && !wr_ctrl |=> !enable_q)
    else $error("underflow kept enable");
  per_kept_a: assert property (advance && !wr_addr |=> $stable(peripheral_addr_field))
    else $error("peripheral field changed");
  idle_no_grant_a: assert property (req_n_s && !bus_hold_o |-> ext_access_grant_n)
    else $error("grant without request");
  grant_req_a: assert property (!bus_hold_o && (req_n_s || cpu_busy_i)
    |=> ext_access_grant_n)
    else $error("grant without cause");
  rom_oe_a: assert property (!rom_cs_n_o |-> !rom_output_enable_n)
    else $error("rom oe not asserted");
  grant_bound_a: assert property (!ext_access_grant_n && (!rom_cs_n_o ||
    !dram_cs_n_o) |-> ##[1:16] ext_access_grant_n)
    else $error("grant not released after access");
endmodule
`default_nettype wire

// ===== dmq_ext_dev.sv
`timescale 1ns/100ps
`default_nettype none
module dmq_ext_dev
  (
  // Clock
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Control from bench
  input wire logic go_i,
  input wire logic [31:0] addr_i,
  output logic done_o,
  // Pins
  input wire logic grant_n_i,
  output logic req_n_o,
  output logic [31:0] bus_o
  );
  // ****************************************
  // Requester
  // ****************************************
  logic [1:0] st_q;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      st_q <= 2'd0;
      req_n_o <= 1'b1;
      bus_o <= 32'h0000_0000;
      done_o <= 1'b0;
    end
    else if (st_q == 2'd0 && go_i)
    begin
      req_n_o <= 1'b0;
      done_o <= 1'b0;
      st_q <= 2'd1;
    end
    else if (st_q == 2'd1 && !grant_n_i)
    begin
      bus_o <= addr_i;
      req_n_o <= 1'b1;
      st_q <= 2'd2;
    end
    else if (st_q == 2'd2 && grant_n_i)
    begin
      bus_o <= ~bus_o;
      done_o <= 1'b1;
      st_q <= 2'd0;
    end
  end
endmodule
`default_nettype wire

// ===== dmq_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dmq_top_tb;
  import dmq_pkg::*;
  localparam logic [31:0] EN = 32'h0000_0001 << DMQ_EN_BIT;
  localparam logic [31:0] QP = 32'h0000_0001 << DMQ_QPEND_BIT;
  localparam logic [31:0] CE = 32'h0000_0001 << DMQ_CTE_BIT;
  localparam logic [31:0] TE = 32'h0000_0001 << DMQ_TTE_BIT;
  localparam logic [31:0] CI = 32'h0000_0001 << DMQ_CTI_BIT;
  localparam logic [31:0] TI = 32'h0000_0001 << DMQ_TTI_BIT;
  localparam logic [31:0] PF = 32'h0000_00A5 << DMQ_PERIPHERAL_ADDR_FIELD_LSB;
  // ****************************************
  // Signals
  // ****************************************
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
  logic pready, pslverr, rerr;
  logic xfer_done = 1'b0, term = 1'b0, busy = 1'b0, go = 1'b0, ce = 1'b1;
  logic [31:0] go_addr = 32'h0000_0000, ch_addr, bus, mem_addr, cap;
  logic active, cirq, tirq, req_n, grant_n, hold, hiz, done;
  logic rom_cs_n, dram_cs_n, oe_n, we_n, aerr;
  logic s_rom, s_dram, s_oe, s_err, s_hold, s_we;
  int n_mismatch = 0;
  int n_tests = 0;
  always #4 mclk_i = ~mclk_i;
  dmq_top dmq_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .xfer_done_i(xfer_done),
    .external_terminate_in(term), .ch_addr_o(ch_addr), .ch_active_o(active),
    .count_end_irq_o(cirq), .terminate_irq_o(tirq),
    .ext_access_request_n(req_n), .cpu_busy_i(busy),
    .shared_data_bus_i(bus), .ext_access_grant_n(grant_n),
    .bus_hold_o(hold), .hiz_force_o(hiz), .mem_addr_o(mem_addr),
    .rom_cs_n_o(rom_cs_n), .dram_cs_n_o(dram_cs_n),
    .rom_output_enable_n(oe_n), .mem_we_n_o(we_n), .addr_err_o(aerr));
  dmq_ext_dev dmq_ext_dev_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go),
    .addr_i(go_addr), .done_o(done), .grant_n_i(grant_n), .req_n_o(req_n),
    .bus_o(bus));
  // ****************************************
  // Access monitor
  // ****************************************
  always @(posedge mclk_i)
  begin
    if (go)
    begin
      {s_rom, s_dram, s_oe, s_err, s_hold, s_we} <= 6'b00_0000;
      cap <= 32'h0000_0000;
    end
    else
    begin
      if (!rom_cs_n) s_rom <= 1'b1;
      if (!dram_cs_n) s_dram <= 1'b1;
      if (!oe_n) s_oe <= 1'b1;
      if (aerr) s_err <= 1'b1;
      if (hold) s_hold <= 1'b1;
      if (!we_n) s_we <= 1'b1;
      if (!rom_cs_n || !dram_cs_n) cap <= mem_addr;
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge mclk_i);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50)
    begin
      n_mismatch++;
      close_out();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata, e);
  endtask
  task automatic done_pulse;
    @(posedge mclk_i);
    xfer_done <= 1'b1;
    @(posedge mclk_i);
    xfer_done <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic ext_go(input logic [31:0] a);
    @(posedge mclk_i);
    go <= 1'b1;
    go_addr <= a;
    @(posedge mclk_i);
    go <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic ext_wait;
    int i;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(posedge mclk_i);
    if (i >= 200)
    begin
      n_mismatch++;
      close_out();
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge mclk_i);
    chk({31'h0, hiz}, 32'h0000_0000);
    rst_n_i <= 1'b1;
    rd(DMQ_CTRL_OFS, DMQ_CTRL_RST);
    rd(DMQ_XCFG_OFS, {28'h000_0000, DMQ_MEM_WAIT_RST});
    apb(1'b1, DMQ_TCNT_OFS, 32'h0000_0000);
    rd(DMQ_TADDR_OFS, 32'h0000_0000);
    apb(1'b1, 8'h20, 32'h1234_5678);
    chk({31'h0, rerr}, 32'h0000_0001);
    apb(1'b1, DMQ_ADDR_OFS, PF | 32'h0000_1000);
    apb(1'b1, DMQ_CNT_OFS, 32'h0000_0000);
    apb(1'b1, DMQ_CTRL_OFS, PF | EN | CE | TE);
    chk({31'h0, active}, 32'h0000_0001);
    apb(1'b1, DMQ_TADDR_OFS, 32'h0000_2000);
    rd(DMQ_CTRL_OFS, PF | EN | CE | TE | QP);
    done_pulse();
    chk(ch_addr, PF | 32'h0000_2000);
    rd(DMQ_CTRL_OFS, PF | EN | CE | TE | CI);
    apb(1'b1, DMQ_TCNT_OFS, 32'h0000_0005);
    apb(1'b1, DMQ_TADDR_OFS, 32'h0000_3000);
    rd(DMQ_CTRL_OFS, PF | EN | CE | TE | QP);
    done_pulse();
    chk(ch_addr, PF | 32'h0000_3000);
    term <= 1'b1;
    repeat (4) @(posedge mclk_i);
    done_pulse();
    term <= 1'b0;
    chk({31'h0, active}, 32'h0000_0000);
    chk({30'h0, tirq, cirq}, 32'h0000_0003);
    rd(DMQ_CTRL_OFS, PF | CE | TE | CI | TI);
    apb(1'b1, DMQ_TCNT_OFS, 32'h0000_0001);
    apb(1'b1, DMQ_TADDR_OFS, 32'h0000_4000);
    rd(DMQ_CTRL_OFS, PF | CE | TE | QP);
    ce <= 1'b0;
    apb(1'b1, DMQ_CTRL_OFS, 32'h0000_0000);
    ce <= 1'b1;
    rd(DMQ_CTRL_OFS, PF | CE | TE | QP);
    busy <= 1'b1;
    ext_go(32'h4000_0010);
    repeat (8) @(posedge mclk_i);
    chk({31'h0, grant_n}, 32'h0000_0001);
    busy <= 1'b0;
    ext_wait();
    chk({29'h0, s_dram, s_rom, s_hold}, 32'h0000_0005);
    chk(cap, 32'h4000_0010);
    chk({31'h0, s_we}, 32'h0000_0001);
    ext_go(32'h0000_0100);
    ext_wait();
    chk({29'h0, s_rom, s_oe, s_dram}, 32'h0000_0006);
    chk(cap, 32'h0000_0100);
    chk({31'h0, s_we}, 32'h0000_0000);
    ext_go(32'h8000_0000);
    ext_wait();
    chk({29'h0, s_err, s_rom, s_dram}, 32'h0000_0004);
    close_out();
  end
endmodule
`default_nettype wire
